// *** verification/esttc_checker.sv ***
// Port-level assertions for the timer's APB slave and interrupt output.
// Bound to esttc_top by the bench; single clock domain sys_clk.
`timescale 1ns/1ps
`default_nettype none

module esttc_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic sleep_mode,
  input wire logic overflow_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_ic_read;
    pready && !pwrite && paddr == 12'h00C;
  endsequence

  property p_answer;
    s_setup ##1 s_access |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no pready after access");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_err_pair;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_pair: assert property (p_err_pair) else $error("pslverr outside an answer");
  property p_idle_data;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("prdata not zero when idle");
  property p_upper_zero;
    pready |-> prdata[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
  property p_hidden;
    pready && paddr > 12'h010 |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_hidden: assert property (p_hidden) else $error("unmapped access not refused");
  property p_mask;
    s_ic_read |-> (prdata[5] || !overflow_irq) && (!(prdata[5] && prdata[2]) || overflow_irq);
  endproperty
  a_mask: assert property (p_mask) else $error("irq disagrees with flag and enable");
  property p_sleep;
    sleep_mode && $past(sleep_mode, 2) && !psel |=> !$rose(overflow_irq);
  endproperty
  a_sleep: assert property (p_sleep) else $error("irq rose during sleep");
  property p_after_reset;
    $past(rst) |-> !overflow_irq && !pready;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("outputs active after reset");
endmodule

`default_nettype wire

// *** verification/test_esttc_top.sv ***
// Self-checking bench for the timer: APB master tasks and directed tests.
// Assumes the defines header on the include path; ext pin driven synchronously.
`timescale 1ns/1ps
`default_nettype none
`include "esttc_defines.svh"

bind esttc_top esttc_checker u_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_mode(sleep_mode), .overflow_irq(overflow_irq));

module test_esttc_top
  import esttc_pkg::*;
;
  localparam logic [11:0] A_CT = `ESTTC_OFF_CTRL;
  localparam logic [11:0] A_LO = `ESTTC_OFF_CNTL;
  localparam logic [11:0] A_HI = `ESTTC_OFF_CNTH;
  localparam logic [11:0] A_IC = `ESTTC_OFF_INTC;
  localparam logic [11:0] A_MS = `ESTTC_OFF_MISC;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, overflow_irq, err;
  logic ext_count_pin = 1'b0, sleep_mode = 1'b0;
  esttc_byte_t rd;
  int failures = 0, tests_run = 0, cycles = 0;

  always #4 sys_clk = ~sys_clk;

  esttc_top DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_pin(ext_count_pin), .sleep_mode(sleep_mode),
    .overflow_irq(overflow_irq));

  task stop_test;
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures = failures + 1;
      stop_test;
    end
  end

  // Range compare; the !== keeps an unknown from passing
  task chk(input string n, input esttc_byte_t lo, input esttc_byte_t hi, input esttc_byte_t got);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("FAIL %s expected %h got %h", n, lo, got);
    end
  endtask

  task xfer(input logic w, input logic [11:0] a, input esttc_byte_t d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input esttc_byte_t d);
    xfer(1'b1, a, d);
  endtask

  task rc(input string n, input logic [11:0] a, input esttc_byte_t e);
    xfer(1'b0, a, 8'h00);
    chk(n, e, e, rd);
  endtask

  // Toggle the pin n times, then let the synchroniser settle
  task toggle(input int n);
    repeat (n) begin
      repeat (8) @(posedge sys_clk);
      ext_count_pin <= ~ext_count_pin;
    end
    repeat (8) @(posedge sys_clk);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rc("ctrl", A_CT, `ESTTC_CTRL_RESET);
    rc("hibuf", A_HI, `ESTTC_CNTH_RESET);
    rc("intc", A_IC, `ESTTC_INTC_RESET);
    rc("unmapped", 12'h100, 8'h00);
    chk("slverr", 8'h01, 8'h01, {7'h00, err});
    wr(A_CT, 8'h08);
    wr(A_HI, 8'h12);
    wr(A_LO, 8'h34);
    wr(A_HI, 8'h55);
    rc("lo", A_LO, 8'h34);
    rc("hi", A_HI, 8'h12);
    wr(A_HI, 8'hFF);
    wr(A_LO, 8'hFE);
    wr(A_IC, 8'h20);
    wr(A_CT, 8'h88);
    repeat (40) @(posedge sys_clk);
    wr(A_CT, 8'h08);
    rc("flag", A_IC, 8'h24);
    chk("irq", 8'h01, 8'h01, {7'h00, overflow_irq});
    xfer(1'b0, A_LO, 8'h00);
    rc("hiwrap", A_HI, 8'h00);
    rc("sticky", A_IC, 8'h24);
    wr(A_IC, 8'h04);
    rc("masked", A_IC, 8'h04);
    chk("irqoff", 8'h00, 8'h00, {7'h00, overflow_irq});
    wr(A_IC, 8'h00);
    rc("clear", A_IC, 8'h00);
    wr(A_CT, 8'h48);
    wr(A_LO, 8'hFE);
    wr(A_CT, 8'hC8);
    repeat (40) @(posedge sys_clk);
    wr(A_CT, 8'h48);
    rc("flag8", A_IC, 8'h04);
    wr(A_IC, 8'h00);
    // Five prescaled counts expected; tick phase allows one either way
    for (int r = 0; r < 8; r++) begin
      wr(A_CT, {5'h00, r[2:0]});
      wr(A_LO, 8'h00);
      wr(A_CT, {5'h10, r[2:0]});
      repeat ((40 << r) - 3) @(posedge sys_clk);
      wr(A_CT, {5'h00, r[2:0]});
      xfer(1'b0, A_LO, 8'h00);
      chk("ratio", 8'h04, 8'h06, rd);
    end
    wr(A_CT, 8'h28);
    wr(A_LO, 8'h00);
    wr(A_CT, 8'hA8);
    toggle(3);
    wr(A_CT, 8'h28);
    rc("rise", A_LO, 8'h02);
    wr(A_CT, 8'h38);
    wr(A_LO, 8'h00);
    wr(A_CT, 8'hB8);
    toggle(1);
    wr(A_CT, 8'h38);
    rc("fall", A_LO, 8'h01);
    wr(A_CT, 8'h88);
    wr(A_LO, 8'h00);
    rc("holdoff", A_LO, 8'h00);
    rc("holdoff2", A_LO, 8'h00);
    sleep_mode <= 1'b1;
    wr(A_CT, 8'h08);
    wr(A_LO, 8'h00);
    wr(A_CT, 8'h88);
    rc("asleep", A_MS, 8'h01);
    repeat (40) @(posedge sys_clk);
    wr(A_CT, 8'h08);
    rc("slept", A_LO, 8'h00);
    sleep_mode <= 1'b0;
    stop_test;
  end
endmodule

`default_nettype wire

// *** verilog/esttc_defines.svh ***
// Register offsets, field positions, reset values and timing counts of the timer.
// Included by the package and the design modules; holds definitions only.
`ifndef ESTTC_DEFINES_SVH
`define ESTTC_DEFINES_SVH

`define ESTTC_OFF_CTRL 12'h000
`define ESTTC_OFF_CNTL 12'h004
`define ESTTC_OFF_CNTH 12'h008
`define ESTTC_OFF_INTC 12'h00C
`define ESTTC_OFF_MISC 12'h010

`define ESTTC_BIT_RUN 7
`define ESTTC_BIT_WIDTH 6
`define ESTTC_BIT_SRC 5
`define ESTTC_BIT_EDGE 4
`define ESTTC_BIT_BYPASS 3
`define ESTTC_BIT_OVF_EN 5
`define ESTTC_BIT_OVF_FLAG 2
`define ESTTC_BIT_SLEEP 0

`define ESTTC_CTRL_RESET 8'hFF
`define ESTTC_CNTH_RESET 8'h00
`define ESTTC_INTC_RESET 8'h00

`define ESTTC_CYC_PER_INSTR 4'h4
`define ESTTC_WRITE_HOLDOFF 2'h2

`endif

// *** verilog/esttc_pkg.sv ***
// Types shared by the timer top and its instruction-cycle tick generator.
// Assumes the defines header is on the include path.
`include "esttc_defines.svh"

package esttc_pkg;
  typedef enum logic [2:0] {
    ESTTC_IDLE = 3'h1,
    ESTTC_ACCESS = 3'h2,
    ESTTC_DONE = 3'h4
  } esttc_bus_state_t;
  typedef logic [7:0] esttc_byte_t;
endpackage

// *** verilog/esttc_tick_gen.sv ***
// Instruction cycle tick: one sys_clk pulse every four clocks.
// Assumes sys_clk and rst as in the top module.
`timescale 1ns/1ps
`default_nettype none

`include "esttc_defines.svh"

module esttc_tick_gen
  import esttc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Tick out
  esttc_tick_if.src tick_port
);
  logic [3:0] phase_ff;
  logic tick_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_ff <= 4'h0;
    end else if (phase_ff == `ESTTC_CYC_PER_INSTR - 4'h1) begin
      phase_ff <= 4'h0;
    end else begin
      phase_ff <= phase_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (phase_ff == `ESTTC_CYC_PER_INSTR - 4'h1);
    end
  end

  assign tick_port.tick = tick_ff;
endmodule

`default_nettype wire

// *** verilog/esttc_tick_if.sv ***
// Carries the instruction-cycle tick from the generator to the timer.
// Assumes one clock domain, sys_clk.
`timescale 1ns/1ps
`default_nettype none

interface esttc_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

`default_nettype wire

// *** verilog/esttc_top.sv ***
// Eight/sixteen-bit timer counter with prescaler, APB register slave.
// Assumes an APB master on sys_clk; ext_count_pin synchronous to sys_clk.
// Summary of operation
// - Control bit 7 set runs the counter, cleared halts it.
// - Control bit 6 set gives 8-bit counting, cleared 16-bit.
// - Control bit 5 set counts pin edges, cleared counts instruction cycles.
// - Control bit 4 set counts falling pin edges, cleared rising edges.
// - Control bit 3 set bypasses the prescaler, cleared uses its output.
// - Ratio bits 2-0 divide by two to the power ratio plus one.
// - Timer mode without prescaler advances once each instruction cycle.
// - A low byte write blocks increments for two instruction cycles.
// - Prescaler is an 8-bit count hidden from software.
// - Low byte write clears the prescaler count only while it is in use (bit 3 clear), assignment untouched.
// - Prescaler assignment may change while the counter runs.
// - Overflow flag sets on wrap FFh to 00h or FFFFh to 0000h.
// - Interrupt output is the flag gated by its enable bit.
// - Sleep halts the counter so no overflow arises during it.
// - Low byte read in 16-bit mode copies true high byte to buffer.
// - Low byte write in 16-bit mode loads true high byte from buffer.
// - True high byte is reached only through the buffer register.
// - Buffer resets to zero; low count byte is left unchanged.
// - Pin input passes a synchroniser before it may advance the count.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

`include "esttc_defines.svh"

module esttc_top
  import esttc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and system
  input wire logic ext_count_pin,
  input wire logic sleep_mode,
  output logic overflow_irq
);
  esttc_tick_if tick_bus ();

  esttc_tick_gen u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick_port(tick_bus)
  );

  esttc_bus_state_t bus_state_ff;
  esttc_bus_state_t nxt_bus_state;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic pready_ff;
  esttc_byte_t ctrl_ff;
  esttc_byte_t cnt_lo_ff;
  esttc_byte_t cnt_hi_ff;
  esttc_byte_t hi_buf_ff;
  logic ovf_flag_ff;
  logic ovf_en_ff;
  logic irq_ff;
  logic [7:0] presc_ff;
  logic [1:0] holdoff_ff;
  logic sync1_ff;
  logic sync2_ff;
  logic pin_last_ff;

  logic run_enable;
  logic width_select;
  logic count_source_select;
  logic count_edge_select;
  logic prescaler_bypass;
  logic [2:0] prescale_ratio;
  logic acc_cycle;
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic wr_intc;
  logic rd_lo;
  logic addr_ok;
  logic sel_ctrl;
  logic sel_lo;
  logic sel_hi;
  logic sel_intc;
  logic sel_misc;
  logic src_event;
  logic presc_out;
  logic count_event;
  logic inc;
  logic [15:0] cnt_cur;
  logic [16:0] cnt_sum;
  logic wrap;
  logic [7:0] presc_nxt;

  assign run_enable = ctrl_ff[`ESTTC_BIT_RUN];
  assign width_select = ctrl_ff[`ESTTC_BIT_WIDTH];
  assign count_source_select = ctrl_ff[`ESTTC_BIT_SRC];
  assign count_edge_select = ctrl_ff[`ESTTC_BIT_EDGE];
  assign prescaler_bypass = ctrl_ff[`ESTTC_BIT_BYPASS];
  assign prescale_ratio = ctrl_ff[2:0];

  // APB access phase handshake; one wait state, answer in the second cycle after setup.
  always_comb begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      ESTTC_IDLE: begin
        if (psel && !penable) begin
          nxt_bus_state = ESTTC_ACCESS;
        end
      end
      ESTTC_ACCESS: begin
        nxt_bus_state = ESTTC_DONE;
      end
      ESTTC_DONE: begin
        nxt_bus_state = ESTTC_IDLE;
      end
      default: begin
        nxt_bus_state = ESTTC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_state_ff <= ESTTC_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // One decode of the held address serves the write strobes and the error answer.
  always_comb begin
    sel_ctrl = 1'b0;
    sel_lo = 1'b0;
    sel_hi = 1'b0;
    sel_intc = 1'b0;
    sel_misc = 1'b0;
    case (paddr)
      `ESTTC_OFF_CTRL: begin
        sel_ctrl = 1'b1;
      end
      `ESTTC_OFF_CNTL: begin
        sel_lo = 1'b1;
      end
      `ESTTC_OFF_CNTH: begin
        sel_hi = 1'b1;
      end
      `ESTTC_OFF_INTC: begin
        sel_intc = 1'b1;
      end
      `ESTTC_OFF_MISC: begin
        sel_misc = 1'b1;
      end
      default: begin
        sel_ctrl = 1'b0;
      end
    endcase
  end

  // The access is acted on once, on the edge that raises pready.
  assign acc_cycle = (bus_state_ff == ESTTC_ACCESS) && psel && penable;
  assign addr_ok = sel_ctrl || sel_lo || sel_hi || sel_intc || sel_misc;
  assign wr_ctrl = acc_cycle && pwrite && sel_ctrl;
  assign wr_lo = acc_cycle && pwrite && sel_lo;
  assign wr_hi = acc_cycle && pwrite && sel_hi;
  assign wr_intc = acc_cycle && pwrite && sel_intc;
  assign rd_lo = acc_cycle && !pwrite && sel_lo;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= acc_cycle;
      pslverr_ff <= acc_cycle && !addr_ok;
    end
  end

  // Read data; the true high byte has no address of its own.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (acc_cycle && !pwrite) begin
      case (paddr)
        `ESTTC_OFF_CTRL: prdata_ff <= {24'h00_0000, ctrl_ff};
        `ESTTC_OFF_CNTL: prdata_ff <= {24'h00_0000, cnt_lo_ff};
        `ESTTC_OFF_CNTH: prdata_ff <= {24'h00_0000, hi_buf_ff};
        `ESTTC_OFF_INTC: prdata_ff <= {24'h00_0000, 2'h0, ovf_en_ff, 2'h0,
                                       ovf_flag_ff, 2'h0};
        `ESTTC_OFF_MISC: prdata_ff <= {31'h0000_0000, sleep_mode};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      prdata_ff <= 32'h0000_0000;
    end
  end

  // Assignment and ratio may change any time; the prescaler keeps running.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `ESTTC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata[7:0];
    end
  end

  // Enable bit only; the flag bit of the same write is handled with the flag.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_en_ff <= 1'b0;
    end else if (wr_intc) begin
      ovf_en_ff <= pwdata[`ESTTC_BIT_OVF_EN];
    end
  end

  // Pin synchroniser; only the second stage feeds the edge detector.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      pin_last_ff <= 1'b0;
    end else begin
      sync1_ff <= ext_count_pin;
      sync2_ff <= sync1_ff;
      pin_last_ff <= sync2_ff;
    end
  end

  // Detector idles low; a pin held high through reset reads as one rising edge.
  always_comb begin
    if (count_source_select) begin
      if (count_edge_select) begin
        src_event = pin_last_ff && !sync2_ff;
      end else begin
        src_event = !pin_last_ff && sync2_ff;
      end
    end else begin
      src_event = tick_bus.tick;
    end
  end

  // Output pulses when bit ratio of the count toggles to zero: divide by 2^(ratio+1).
  assign presc_nxt = presc_ff + 8'h01;
  assign presc_out = src_event && (presc_nxt[prescale_ratio] == 1'b0) &&
                     (presc_ff[prescale_ratio] == 1'b1);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      presc_ff <= 8'h00;
    end else if (wr_lo && !prescaler_bypass) begin
      presc_ff <= 8'h00;
    end else if (src_event && run_enable && !sleep_mode) begin
      presc_ff <= presc_nxt;
    end
  end

  assign count_event = prescaler_bypass ? src_event : presc_out;

  // Holdoff counts instruction cycles after a low byte write.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      holdoff_ff <= 2'h0;
    end else if (wr_lo) begin
      holdoff_ff <= `ESTTC_WRITE_HOLDOFF;
    end else if (tick_bus.tick && holdoff_ff != 2'h0) begin
      holdoff_ff <= holdoff_ff - 2'h1;
    end
  end

  // A low byte write wins over a count that lands in the same cycle.
  assign inc = count_event && run_enable && !sleep_mode && (holdoff_ff == 2'h0) &&
               !wr_lo;
  assign cnt_cur = {cnt_hi_ff, cnt_lo_ff};
  assign cnt_sum = {1'b0, cnt_cur} + 17'h0_0001;
  // In 8-bit mode the high byte plays no part in overflow.
  assign wrap = inc && (width_select ? (cnt_lo_ff == 8'hFF)
                                     : (cnt_cur == 16'hFFFF));

  // Low byte keeps its value through reset; only a write or a count moves it.
  always_ff @(posedge sys_clk) begin
    if (wr_lo) begin
      cnt_lo_ff <= pwdata[7:0];
    end else if (inc) begin
      cnt_lo_ff <= cnt_sum[7:0];
    end
  end

  // In 8-bit mode the true high byte is frozen; only a 16-bit low write loads it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_hi_ff <= 8'h00;
    end else if (wr_lo && !width_select) begin
      cnt_hi_ff <= hi_buf_ff;
    end else if (inc && !width_select) begin
      cnt_hi_ff <= cnt_sum[15:8];
    end
  end

  // Buffer is loaded from the true high byte on a 16-bit low byte read.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hi_buf_ff <= `ESTTC_CNTH_RESET;
    end else if (wr_hi) begin
      hi_buf_ff <= pwdata[7:0];
    end else if (rd_lo && !width_select) begin
      hi_buf_ff <= cnt_hi_ff;
    end
  end

  // Set wins over a software clear in the same cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_flag_ff <= 1'b0;
    end else if (wrap) begin
      ovf_flag_ff <= 1'b1;
    end else if (wr_intc && !pwdata[`ESTTC_BIT_OVF_FLAG]) begin
      ovf_flag_ff <= 1'b0;
    end
  end

  // Registered so the pin comes from a flip-flop; it lags the flag by one cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= ovf_flag_ff && ovf_en_ff;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign overflow_irq = irq_ff;
endmodule

`default_nettype wire
